// [hdl/ssm_top.sv]
/*
 * Stop-option and mode-select logic: holds the stop option objects, runs the
 * stop sequence for quick stop, shutdown, disable operation, halt and faults,
 * and manages operating mode changes.
 * Assumes the drive state machine issues one-cycle event pulses, the motion
 * core reports axis_stopped and homing_busy, and the object dictionary port
 * issues single-cycle od_wr or od_rd strobes.
 */
// How it works
// - quick-stop option, codes 0,1,2,5,6, reset 2
// - quick-stop code 0: servo off, stop method
// - codes 1,2 ramp then No Fault
// - codes 5,6 ramp then hold Quick Stop
// - shutdown option 0 servo off, 1 ramp
// - disable-operation option 0 off, 1 ramp
// - halt bit ramps with halt option decel
// - fault reaction: servo off, stop method
// - supported modes read-only word 0x03ed
// - unsupported and reserved mode bits read zero
// - mode request 8-bit, 0 to 10, reset 0
// - decode mode values; 2 and 5 unassigned
// - mode display shows active mode, reset 0
// - leaving PP or CSP discards positions
// - leaving velocity/torque modes ramps stop first
// - no mode change while homing runs
// - codes 0,1,2 return to No Fault alone
// - codes 5,6 hold until enable, shutdown or disable command, or alarm

`timescale 1ns/1ns
`default_nettype none
module ssm_top #(
	parameter int CYC_SETTLE = ssm_pkg::SETTLE_CYC
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [15:0] od_index,
	input wire logic od_wr,
	input wire logic od_rd,
	input wire logic [31:0] od_wdata,
	output logic [31:0] od_rdata,
	output logic od_ack,
	output logic od_err,
	input wire logic quick_stop_cmd,
	input wire logic shutdown_cmd,
	input wire logic disable_op_cmd,
	input wire logic enable_op_cmd,
	input wire logic alarm,
	input wire logic halt,
	input wire logic axis_stopped,
	input wire logic homing_busy,
	output logic ramp_active,
	output logic decel_quick,
	output logic servo_off,
	output logic off_stop_sel,
	output logic quick_stop_hold,
	output logic enter_no_fault,
	output logic enter_fault,
	output logic discard_pos,
	output logic [7:0] mode_display,
	output logic cyclic_settling
);
	import ssm_pkg::*;

	localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(CYC_SETTLE);

	ssm_state_t s_reg;
	ssm_state_t s_next;

	function automatic logic qs_valid(input logic [15:0] v);
		qs_valid = (v == OPT_SERVO_OFF) || (v == OPT_PROFILE_NF) || (v == OPT_QUICK_NF) ||
			(v == OPT_PROFILE_HOLD) || (v == OPT_QUICK_HOLD);
	endfunction

	function automatic logic mode_valid(input logic [31:0] v);
		mode_valid = (v[31:8] == 24'h000000) && ((v[7:0] == MODE_NONE) || (v[7:0] == MODE_PP) ||
			(v[7:0] == MODE_PV) || (v[7:0] == MODE_PT) || (v[7:0] == MODE_HM) ||
			(v[7:0] == MODE_IP) || (v[7:0] == MODE_CSP) || (v[7:0] == MODE_CSV) ||
			(v[7:0] == MODE_CST));
	endfunction

	// velocity and torque modes ramp to rest before leaving
	function automatic logic is_ramp_mode(input logic [7:0] m);
		is_ramp_mode = (m == MODE_PV) || (m == MODE_CSV) || (m == MODE_PT) || (m == MODE_CST);
	endfunction

	logic wr_ok;
	logic hi_zero;
	logic mode_pending;
	logic take_mode;

	always_comb begin
		s_next = s_reg;
		s_next.ack = 1'b0;
		s_next.err = 1'b0;
		s_next.nf_pulse = 1'b0;
		s_next.fault_pulse = 1'b0;
		s_next.discard = 1'b0;
		wr_ok = 1'b0;
		take_mode = 1'b0;
		hi_zero = (od_wdata[31:16] == 16'h0000);

		// object dictionary access
		// 16-bit options need a clear upper half, so negative codes are refused
		if (od_wr) begin
			s_next.ack = 1'b1;
			unique case (od_index)
				IDX_QUICK_STOP_OPTION: begin
					wr_ok = hi_zero && qs_valid(od_wdata[15:0]);
					if (wr_ok) begin
						s_next.qs_opt = od_wdata[15:0];
					end
				end
				IDX_SHUTDOWN_OPTION: begin
					wr_ok = hi_zero &&
						(od_wdata[15:0] == OPT_SERVO_OFF || od_wdata[15:0] == OPT_PROFILE_NF);
					if (wr_ok) begin
						s_next.sd_opt = od_wdata[15:0];
					end
				end
				IDX_DISABLE_OPERATION_OPTION: begin
					wr_ok = hi_zero &&
						(od_wdata[15:0] == OPT_SERVO_OFF || od_wdata[15:0] == OPT_PROFILE_NF);
					if (wr_ok) begin
						s_next.do_opt = od_wdata[15:0];
					end
				end
				IDX_HALT_OPTION: begin
					wr_ok = hi_zero &&
						(od_wdata[15:0] == OPT_HALT_PROFILE || od_wdata[15:0] == OPT_HALT_QUICK);
					if (wr_ok) begin
						s_next.halt_opt = od_wdata[15:0];
					end
				end
				IDX_FAULT_REACTION_OPTION: begin
					wr_ok = hi_zero && (od_wdata[15:0] == OPT_SERVO_OFF);
					if (wr_ok) begin
						s_next.fr_opt = od_wdata[15:0];
					end
				end
				IDX_MODE_REQUEST: begin
					wr_ok = mode_valid(od_wdata);
					if (wr_ok) begin
						s_next.req = od_wdata[7:0];
					end
				end
				default: wr_ok = 1'b0;
			endcase
			s_next.err = !wr_ok;
		end else if (od_rd) begin
			// options read back sign-extended as 16-bit signed objects
			s_next.ack = 1'b1;
			unique case (od_index)
				IDX_QUICK_STOP_OPTION: s_next.rdata = {{16{s_reg.qs_opt[15]}}, s_reg.qs_opt};
				IDX_SHUTDOWN_OPTION: s_next.rdata = {{16{s_reg.sd_opt[15]}}, s_reg.sd_opt};
				IDX_DISABLE_OPERATION_OPTION: s_next.rdata = {{16{s_reg.do_opt[15]}}, s_reg.do_opt};
				IDX_HALT_OPTION: s_next.rdata = {{16{s_reg.halt_opt[15]}}, s_reg.halt_opt};
				IDX_FAULT_REACTION_OPTION: s_next.rdata = {{16{s_reg.fr_opt[15]}}, s_reg.fr_opt};
				IDX_MODE_REQUEST: s_next.rdata = {24'h000000, s_reg.req};
				IDX_MODE_DISPLAY: s_next.rdata = {24'h000000, s_reg.disp};
				IDX_SUPPORTED_MODES: s_next.rdata = SUPPORTED_MODES;
				default: begin
					s_next.rdata = 32'h0000_0000;
					s_next.err = 1'b1;
				end
			endcase
		end

		// settle window: cyclic commands from the host are not safe yet
		if (s_reg.settle != '0) begin
			s_next.settle = s_reg.settle - SETTLE_W'(1);
		end

		// a change waits while homing runs
		mode_pending = (s_reg.req != MODE_NONE) && (s_reg.req != s_reg.disp) &&
			!((s_reg.disp == MODE_HM) && homing_busy);

		// stop sequencer; alarm wins over everything
		// a held alarm level does not restart a fault stop already running
		if (alarm && !(s_reg.st == ST_SERVO_OFF && s_reg.why == WHY_FAULT)) begin
			s_next.st = ST_SERVO_OFF;
			s_next.why = WHY_FAULT;
			s_next.sel2 = 1'b0;
		end else begin
			unique case (s_reg.st)
				ST_IDLE, ST_MODE_RAMP: begin
					if (quick_stop_cmd) begin
						unique case (s_reg.qs_opt)
							OPT_SERVO_OFF: begin
								s_next.st = ST_SERVO_OFF;
								s_next.why = WHY_NO_FAULT;
								s_next.sel2 = 1'b0;
							end
							OPT_PROFILE_NF, OPT_QUICK_NF: begin
								s_next.st = ST_RAMP;
								s_next.why = WHY_NO_FAULT;
								s_next.quick = (s_reg.qs_opt == OPT_QUICK_NF);
							end
							default: begin
								s_next.st = ST_RAMP;
								s_next.why = WHY_QS_HOLD;
								s_next.quick = (s_reg.qs_opt == OPT_QUICK_HOLD);
							end
						endcase
					end else if (shutdown_cmd || disable_op_cmd) begin
						s_next.why = WHY_NO_FAULT;
						s_next.quick = 1'b0;
						s_next.sel2 = disable_op_cmd;
						if ((shutdown_cmd && s_reg.sd_opt == OPT_PROFILE_NF) ||
							(disable_op_cmd && s_reg.do_opt == OPT_PROFILE_NF)) begin
							s_next.st = ST_RAMP;
						end else begin
							s_next.st = ST_SERVO_OFF;
						end
					end else if (mode_pending && is_ramp_mode(s_reg.disp) && !axis_stopped) begin
						s_next.st = ST_MODE_RAMP;
						s_next.quick = 1'b0;
					end else if (mode_pending) begin
						take_mode = 1'b1;
						s_next.st = ST_IDLE;
					end else if (s_reg.st == ST_MODE_RAMP) begin
						s_next.st = ST_IDLE;
					end
				end
				ST_RAMP, ST_SERVO_OFF: begin
					// further quick stop, shutdown and disable events are ignored until the axis rests
					if (axis_stopped) begin
						unique case (s_reg.why)
							WHY_QS_HOLD: s_next.st = ST_QS_HOLD;
							WHY_FAULT: begin
								s_next.st = ST_IDLE;
								s_next.fault_pulse = 1'b1;
							end
							default: begin
								s_next.st = ST_IDLE;
								s_next.nf_pulse = 1'b1;
							end
						endcase
					end
				end
				ST_QS_HOLD: begin
					// shutdown or disable from the hold also ends in No Fault
					if (enable_op_cmd) begin
						s_next.st = ST_IDLE;
					end else if (shutdown_cmd || disable_op_cmd) begin
						s_next.st = ST_IDLE;
						s_next.nf_pulse = 1'b1;
					end
				end
				default: s_next.st = ST_IDLE;
			endcase
		end

		// the mode being left decides the discard; a cyclic target opens the settle window
		if (take_mode) begin
			s_next.disp = s_reg.req;
			s_next.discard = (s_reg.disp == MODE_PP) || (s_reg.disp == MODE_CSP);
			if (s_reg.req == MODE_CSP || s_reg.req == MODE_CSV || s_reg.req == MODE_CST) begin
				s_next.settle = SETTLE_LOAD;
			end
		end

		// reset last, so it overrides a write in the same cycle
		if (sys_rst) begin
			s_next = '0;
			s_next.st = ST_IDLE;
			s_next.why = WHY_NO_FAULT;
			s_next.qs_opt = RST_QUICK_STOP_OPTION;
			s_next.sd_opt = RST_SHUTDOWN_OPTION;
			s_next.do_opt = RST_DISABLE_OPERATION_OPTION;
			s_next.halt_opt = RST_HALT_OPTION;
			s_next.fr_opt = RST_FAULT_REACTION_OPTION;
			s_next.req = RST_MODE;
			s_next.disp = RST_MODE;
		end
	end

	always_ff @(posedge clock) begin
		s_reg <= s_next;
	end

	always_comb begin
		// halt ramps only while no stop sequence owns the axis
		ramp_active = (s_reg.st == ST_RAMP) || (s_reg.st == ST_MODE_RAMP) ||
			((s_reg.st == ST_IDLE) && halt);
		if (s_reg.st == ST_IDLE) begin
			decel_quick = halt && (s_reg.halt_opt == OPT_HALT_QUICK);
		end else begin
			decel_quick = (s_reg.st == ST_RAMP) && s_reg.quick;
		end
	end

	assign servo_off = (s_reg.st == ST_SERVO_OFF);
	assign off_stop_sel = s_reg.sel2;
	assign quick_stop_hold = (s_reg.st == ST_QS_HOLD);
	assign enter_no_fault = s_reg.nf_pulse;
	assign enter_fault = s_reg.fault_pulse;
	assign discard_pos = s_reg.discard;
	assign mode_display = s_reg.disp;
	assign cyclic_settling = (s_reg.settle != '0);
	assign od_rdata = s_reg.rdata;
	assign od_ack = s_reg.ack;
	assign od_err = s_reg.err;
endmodule
`default_nettype wire

// [hdl/ssm_pkg.sv]
/*
 * Constants and types for the stop-option and mode-select logic of a servo
 * drive object dictionary.
 * Assumes one drive clock at 100 MHz and a synchronous reset.
 */
package ssm_pkg;
	// object dictionary indices
	localparam logic [15:0] IDX_QUICK_STOP_OPTION = 16'h605a;
	localparam logic [15:0] IDX_SHUTDOWN_OPTION = 16'h605b;
	localparam logic [15:0] IDX_DISABLE_OPERATION_OPTION = 16'h605c;
	localparam logic [15:0] IDX_HALT_OPTION = 16'h605d;
	localparam logic [15:0] IDX_FAULT_REACTION_OPTION = 16'h605e;
	localparam logic [15:0] IDX_MODE_REQUEST = 16'h6060;
	localparam logic [15:0] IDX_MODE_DISPLAY = 16'h6061;
	localparam logic [15:0] IDX_SUPPORTED_MODES = 16'h6502;

	// values after reset
	localparam logic [15:0] RST_QUICK_STOP_OPTION = 16'h0002;
	localparam logic [15:0] RST_SHUTDOWN_OPTION = 16'h0000;
	localparam logic [15:0] RST_DISABLE_OPERATION_OPTION = 16'h0000;
	localparam logic [15:0] RST_HALT_OPTION = 16'h0001;
	localparam logic [15:0] RST_FAULT_REACTION_OPTION = 16'h0000;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [31:0] SUPPORTED_MODES = 32'h0000_03ed;

	// option codes
	localparam logic [15:0] OPT_SERVO_OFF = 16'h0000;
	localparam logic [15:0] OPT_PROFILE_NF = 16'h0001;
	localparam logic [15:0] OPT_QUICK_NF = 16'h0002;
	localparam logic [15:0] OPT_PROFILE_HOLD = 16'h0005;
	localparam logic [15:0] OPT_QUICK_HOLD = 16'h0006;
	localparam logic [15:0] OPT_HALT_PROFILE = 16'h0001;
	localparam logic [15:0] OPT_HALT_QUICK = 16'h0002;

	// mode codes
	localparam logic [7:0] MODE_NONE = 8'h00;
	localparam logic [7:0] MODE_PP = 8'h01;
	localparam logic [7:0] MODE_PV = 8'h03;
	localparam logic [7:0] MODE_PT = 8'h04;
	localparam logic [7:0] MODE_HM = 8'h06;
	localparam logic [7:0] MODE_IP = 8'h07;
	localparam logic [7:0] MODE_CSP = 8'h08;
	localparam logic [7:0] MODE_CSV = 8'h09;
	localparam logic [7:0] MODE_CST = 8'h0a;

	// settle time after entering a cyclic mode
	localparam int CLOCK_MHZ = 100;
	localparam int SETTLE_US = 1000;
	localparam int SETTLE_CYC = SETTLE_US * CLOCK_MHZ;
	localparam int SETTLE_W = 17;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RAMP = 3'b001,
		ST_SERVO_OFF = 3'b010,
		ST_QS_HOLD = 3'b011,
		ST_MODE_RAMP = 3'b100
	} ssm_stop_t;

	// what the stop sequence leads to once the axis rests
	typedef enum logic [1:0] {
		WHY_NO_FAULT = 2'b00,
		WHY_QS_HOLD = 2'b01,
		WHY_FAULT = 2'b10
	} ssm_why_t;

	typedef struct packed {
		ssm_stop_t st;
		ssm_why_t why;
		logic quick;
		logic sel2;
		logic [15:0] qs_opt;
		logic [15:0] sd_opt;
		logic [15:0] do_opt;
		logic [15:0] halt_opt;
		logic [15:0] fr_opt;
		logic [7:0] req;
		logic [7:0] disp;
		logic [SETTLE_W-1:0] settle;
		logic [31:0] rdata;
		logic ack;
		logic err;
		logic nf_pulse;
		logic fault_pulse;
		logic discard;
	} ssm_state_t;
endpackage

// [bench/ssm_props.sv]
/* port assertions for ssm_top
   assumes one clock domain with synchronous sys_rst */
`timescale 1ns/1ns
`default_nettype none
module ssm_props (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [15:0] od_index,
	input wire logic od_wr,
	input wire logic [31:0] od_wdata,
	input wire logic od_ack,
	input wire logic od_err,
	input wire logic shutdown_cmd,
	input wire logic disable_op_cmd,
	input wire logic enable_op_cmd,
	input wire logic alarm,
	input wire logic axis_stopped,
	input wire logic homing_busy,
	input wire logic servo_off,
	input wire logic quick_stop_hold,
	input wire logic enter_no_fault,
	input wire logic enter_fault,
	input wire logic discard_pos,
	input wire logic [7:0] mode_display
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_ro_write_err: assert property (od_wr && od_index inside {16'h6061, 16'h6502}
		|=> od_ack && od_err)
		else $error("read-only write not refused");
	a_bad_qs_code: assert property (od_wr && od_index == 16'h605a &&
		!(od_wdata inside {32'h0, 32'h1, 32'h2, 32'h5, 32'h6}) |=> od_err)
		else $error("bad quick stop code taken");
	a_bad_mode_code: assert property (od_wr && od_index == 16'h6060 &&
		od_wdata inside {32'h2, 32'h5} |=> od_err)
		else $error("unassigned mode taken");
	a_servo_off_held: assert property (servo_off && !axis_stopped |=> servo_off)
		else $error("power back before rest");
	a_fault_end: assert property (enter_fault |-> !servo_off && $past(axis_stopped))
		else $error("fault stop end wrong");
	a_nf_pulse: assert property (enter_no_fault |=> !enter_no_fault)
		else $error("no fault pulse too long");
	a_hold_kept: assert property (quick_stop_hold &&
		!(enable_op_cmd || shutdown_cmd || disable_op_cmd || alarm) |=> quick_stop_hold)
		else $error("quick stop hold lost");
	a_disp_legal: assert property (mode_display inside
		{8'h0, 8'h1, 8'h3, 8'h4, 8'h6, 8'h7, 8'h8, 8'h9, 8'ha})
		else $error("illegal mode shown");
	a_discard_on_leave: assert property (discard_pos |->
		$past(mode_display) inside {8'h1, 8'h8} && $changed(mode_display))
		else $error("discard without leaving position mode");
	a_homing_locks: assert property (mode_display == 8'h6 && homing_busy |=> $stable(mode_display))
		else $error("mode changed during homing");
	a_stop_before_change: assert property ($changed(mode_display) &&
		$past(mode_display) inside {8'h3, 8'h4, 8'h9, 8'ha} |-> $past(axis_stopped))
		else $error("mode left while moving");
endmodule
bind ssm_top ssm_props u_props (.*);
`default_nettype wire

// [bench/ssm_axis.sv]
/* axis model: starts moving on go, comes to rest lim+1 cycles into a ramp or servo off
   assumes ramp_active and servo_off from ssm_top */
`timescale 1ns/1ns
`default_nettype none
module ssm_axis (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic go,
	input wire logic [3:0] lim,
	input wire logic ramp_active,
	input wire logic servo_off,
	output logic axis_stopped
);
	logic moving_reg;
	logic [3:0] cnt_reg;
	assign axis_stopped = !moving_reg;
	always_ff @(posedge clock) begin
		if (sys_rst)
			moving_reg <= 1'h0;
		else if (go)
			moving_reg <= 1'h1;
		else if ((ramp_active || servo_off) && cnt_reg == lim)
			moving_reg <= 1'h0;
		if (go || !(ramp_active || servo_off))
			cnt_reg <= 4'h0;
		else if (cnt_reg != lim)
			cnt_reg <= cnt_reg + 4'h1;
	end
endmodule
`default_nettype wire

// [bench/tb_servo_stop_and_mode_select.sv]
/* testbench of ssm_top with the axis model
   assumes ssm_pkg, ssm_top, ssm_axis and ssm_props compiled first */
`timescale 1ns/1ns
`default_nettype none
module tb_servo_stop_and_mode_select;
	import ssm_pkg::*;
	logic clock = '0, sys_rst = 1'h1, od_wr = '0, od_rd = '0, halt = '0, homing_busy = '0, go = '0;
	logic quick_stop_cmd = '0, shutdown_cmd = '0, disable_op_cmd = '0, enable_op_cmd = '0, alarm = '0;
	logic [15:0] od_index = '0;
	logic [31:0] od_wdata = '0, od_rdata;
	logic [3:0] lim = 4'h2;
	logic od_ack, od_err, axis_stopped, ramp_active, decel_quick, servo_off, off_stop_sel;
	logic quick_stop_hold, enter_no_fault, enter_fault, discard_pos, cyclic_settling;
	logic [7:0] mode_display;
	int n_fail = 0, n_compared = 0;
	ssm_top #(.CYC_SETTLE(20)) DUT (.*);
	ssm_axis u_axis (.*);
	initial forever #5 clock = ~clock;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic od(input logic w, input logic [15:0] i, input logic [31:0] d, input logic e);
		@(posedge clock);
		od_wr <= w;
		od_rd <= !w;
		od_index <= i;
		od_wdata <= d;
		@(posedge clock);
		od_wr <= '0;
		od_rd <= '0;
		#1;
		chk({od_ack, od_err}, {1'h1, e});
	endtask
	// bits: go, quick stop, shutdown, disable, enable, alarm
	task automatic ev(input logic [5:0] v);
		@(posedge clock);
		{go, quick_stop_cmd, shutdown_cmd, disable_op_cmd, enable_op_cmd, alarm} <= v;
		@(posedge clock);
		{go, quick_stop_cmd, shutdown_cmd, disable_op_cmd, enable_op_cmd, alarm} <= '0;
		#1;
	endtask
	task automatic wt;
		for (int k = 0; k < 40 && !(enter_no_fault || quick_stop_hold || enter_fault); k++) begin
			@(posedge clock);
			#1;
		end
	endtask
	task automatic wm(input logic [7:0] m);
		od(1'h1, IDX_MODE_REQUEST, {24'h0, m}, 1'h0);
		for (int k = 0; k < 40 && mode_display !== m; k++) begin
			@(posedge clock);
			#1;
		end
		chk(mode_display, m);
	endtask
	task automatic t_reset;
		logic [15:0] ix [8] = '{16'h605a, 16'h605b, 16'h605c, 16'h605d, 16'h605e, 16'h6060, 16'h6061, 16'h6502};
		logic [31:0] ex [8] = '{32'h2, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h3ed};
		foreach (ix[k]) begin
			od(1'h0, ix[k], '0, 1'h0);
			chk(od_rdata, ex[k]);
		end
		od(1'h1, IDX_SUPPORTED_MODES, 32'h0, 1'h1);
		od(1'h1, IDX_MODE_DISPLAY, 32'h1, 1'h1);
		od(1'h1, 16'h6000, 32'h0, 1'h1);
	endtask
	task automatic t_codes;
		od(1'h1, IDX_QUICK_STOP_OPTION, 32'h3, 1'h1);
		od(1'h1, IDX_SHUTDOWN_OPTION, 32'h2, 1'h1);
		od(1'h1, IDX_HALT_OPTION, 32'h0, 1'h1);
		od(1'h1, IDX_MODE_REQUEST, 32'h5, 1'h1);
		od(1'h1, IDX_MODE_REQUEST, 32'hb, 1'h1);
		od(1'h0, IDX_QUICK_STOP_OPTION, 32'h0, 1'h0);
		chk(od_rdata, 32'h2);
	endtask
	task automatic t_quick;
		logic [15:0] op [5] = '{16'h0, 16'h1, 16'h2, 16'h5, 16'h6};
		logic [15:0] q;
		foreach (op[k]) begin
			q = op[k];
			od(1'h1, IDX_QUICK_STOP_OPTION, {16'h0, q}, 1'h0);
			ev(6'h30);
			chk({servo_off, off_stop_sel, ramp_active, decel_quick}, {q == 0, 1'h0, q != 0, q == 2 || q == 6});
			wt;
			chk({enter_no_fault, quick_stop_hold}, {q < 5, q >= 5});
			if (q >= 5) begin
				ev(6'h02);
				chk(quick_stop_hold, 1'h0);
			end
		end
	endtask
	task automatic t_leave;
		for (int s = 0; s < 2; s++)
			for (int o = 0; o < 2; o++) begin
				od(1'h1, IDX_SHUTDOWN_OPTION + 16'(s), 32'(o), 1'h0);
				ev(s ? 6'h24 : 6'h28);
				chk({servo_off, ramp_active, decel_quick}, {o == 0, o == 1, 1'h0});
				if (o == 0) chk(off_stop_sel, 32'(s));
				wt;
				chk(enter_no_fault, 1'h1);
			end
	endtask
	task automatic t_halt;
		for (int h = 1; h < 3; h++) begin
			od(1'h1, IDX_HALT_OPTION, 32'(h), 1'h0);
			@(posedge clock);
			halt <= 1'h1;
			#1;
			chk({ramp_active, decel_quick}, {1'h1, h == 2});
			@(posedge clock);
			halt <= '0;
		end
	endtask
	task automatic t_alarm;
		od(1'h1, IDX_FAULT_REACTION_OPTION, 32'h0, 1'h0);
		ev(6'h21);
		chk({servo_off, off_stop_sel}, 2'h2);
		wt;
		chk(enter_fault, 1'h1);
	endtask
	task automatic t_mode;
		int n;
		lim <= 4'h6;
		wm(MODE_PP);
		od(1'h1, IDX_MODE_REQUEST, 32'h0, 1'h0);
		repeat (2) @(posedge clock);
		#1;
		chk(mode_display, MODE_PP);
		wm(MODE_CSP);
		chk({discard_pos, cyclic_settling}, 2'h3);
		for (n = 0; cyclic_settling === 1'h1 && n < 40; n++) begin
			@(posedge clock);
			#1;
		end
		chk(n, 32'h14);
		wm(MODE_PV);
		chk(discard_pos, 1'h1);
		ev(6'h20);
		od(1'h1, IDX_MODE_REQUEST, 32'h9, 1'h0);
		@(posedge clock);
		#1;
		chk({ramp_active, decel_quick, mode_display}, {2'h2, MODE_PV});
		wm(MODE_CSV);
		wm(MODE_HM);
		@(posedge clock);
		homing_busy <= 1'h1;
		od(1'h1, IDX_MODE_REQUEST, 32'h1, 1'h0);
		repeat (4) @(posedge clock);
		#1;
		chk(mode_display, MODE_HM);
		@(posedge clock);
		homing_busy <= '0;
		wm(MODE_PP);
		wm(MODE_PT);
		chk(discard_pos, 1'h1);
		wm(MODE_IP);
		chk(discard_pos, 1'h0);
		wm(MODE_CST);
		chk({discard_pos, cyclic_settling}, 2'h1);
	endtask
	task automatic tally_and_finish;
		if (n_fail == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock);
		sys_rst <= '0;
		t_reset;
		t_codes;
		t_quick;
		t_leave;
		t_halt;
		t_alarm;
		t_mode;
		tally_and_finish;
	end
	initial begin
		repeat (5000) @(posedge clock);
		n_fail++;
		$display("MISMATCH %0t watchdog", $time);
		tally_and_finish;
	end
endmodule
`default_nettype wire
